// >>> design/afpm_monitor.sv
// Adaptive PID fluctuation monitor for one channel: evaluation gating,
// notification, reference band, average deviation and PID set handling.
// Assumes the PID arithmetic and autotuning run outside and pulse results in.
`default_nettype none

module afpm_monitor
    import afpm_pkg::*;
(
    input wire logic ref_clk, // 20 MHz system clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [5:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic ctrl_start, // Pulse: control run begins
    input wire logic [15:0] pv, // Measured value, tenths degC
    input wire logic at_done, // Pulse: autotuning finished
    input wire afpm_pkg::afpm_model_type at_model, // Model from autotuning
    input wire logic eval_done, // Pulse: evaluation results ready
    input wire afpm_pkg::afpm_pid_type eval_pid, // Newly computed PID sets
    output afpm_pkg::afpm_pid_type act_pid, // PID sets in use
    output afpm_pkg::afpm_model_type model, // Model parameters
    output logic eval_state // Evaluation running
);
    import afpm_pkg::*;

    afpm_state_type state_q;
    afpm_mode_type mode_q;
    afpm_pid_type pend_q;
    logic [15:0] ref_dev_q, op_dev_q, ref_pb_q, avg_q, sp_q;
    logic upd_cmd_q, upd_prev_q, notify_q, upd_en_q, ack_q;
    logic [1:0] cnt_q;
    logic [31:0] rdata_d;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // Bus handshake: every access answers on the second cycle
    wire req = avs_read | avs_write;
    wire wr_now = avs_write & ack_q;
    assign avs_waitrequest = req & ~ack_q;

    wire sel_ctrl = (avs_address == OFF_CTRL);
    wire sel_status = (avs_address == OFF_STATUS);
    wire sel_ref_dev = (avs_address == OFF_REF_DEV);
    wire sel_op_dev = (avs_address == OFF_OP_DEV);
    wire sel_ref_pb = (avs_address == OFF_REF_PB);
    wire sel_avg = (avs_address == OFF_AVG_DEV);
    wire sel_sp = (avs_address == OFF_SETPOINT);
    wire sel_model = (avs_address >= OFF_MODEL0) && (avs_address <= OFF_MODEL3)
                     && (avs_address[1:0] == 2'b00);
    wire sel_act = (avs_address == OFF_ACT_PB);
    wire [1:0] midx = avs_address[3:2];

    wire [15:0] model_rd = (midx == 2'h0) ? model.pv_amp :
                           (midx == 2'h1) ? model.mv_amp :
                           (midx == 2'h2) ? model.on_time : model.off_time;
    wire [31:0] status_word = {24'h0, 2'b00, cnt_q, 1'b0, upd_en_q, notify_q, eval_state};

    always_comb begin
        rdata_d = 32'h0;
        if (sel_ctrl) begin
            rdata_d = {29'h0, upd_cmd_q, mode_q};
        end else if (sel_status) begin
            rdata_d = status_word;
        end else if (sel_ref_dev) begin
            rdata_d = {16'h0, ref_dev_q};
        end else if (sel_op_dev) begin
            rdata_d = {16'h0, op_dev_q};
        end else if (sel_ref_pb) begin
            rdata_d = {16'h0, ref_pb_q};
        end else if (sel_avg) begin
            rdata_d = {16'h0, avg_q};
        end else if (sel_sp) begin
            rdata_d = {16'h0, sp_q};
        end else if (sel_model) begin
            rdata_d = {16'h0, model_rd};
        end else if (sel_act) begin
            rdata_d = {16'h0, act_pid.sp_pb};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read & ~ack_q) begin
                avs_readdata <= rdata_d;
            end
        end
    end

    // Evaluation gate: start value within op_dev share of 0..set point
    wire [31:0] pv_scaled = pv * PCT_SCALE;
    wire [31:0] sp_scaled = sp_q * op_dev_q;
    wire start_ok = (pv_scaled <= sp_scaled);
    wire eval_mode = (mode_q == AFPM_NOTIFY) || (mode_q == AFPM_AUTO);
    wire go_eval = ctrl_start && eval_mode && start_ok && (state_q == ST_IDLE);

    // Comparison against the band stored before this evaluation
    logic calc_done, calc_fluct;
    logic [15:0] calc_pct;
    afpm_fluct_calc u_calc (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(eval_done && (state_q == ST_EVAL)),
        .ref_pb(ref_pb_q),
        .new_pb(eval_pid.sp_pb),
        .ref_dev(ref_dev_q),
        .done(calc_done),
        .fluct(calc_fluct),
        .pct(calc_pct)
    );

    // pct is registered one cycle after done
    logic fin_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            fin_q <= 1'b0;
        end else begin
            fin_q <= calc_done;
            case (state_q)
                ST_IDLE: begin
                    if (go_eval) begin
                        state_q <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    if (!eval_mode) begin
                        state_q <= ST_IDLE;
                    end else if (eval_done) begin
                        state_q <= ST_CALC;
                    end
                end
                default: begin
                    if (fin_q) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    assign eval_state = (state_q != ST_IDLE);

    wire settled = (cnt_q == SETTLE_EVAL_NUM);
    wire upd_rise = upd_cmd_q & ~upd_prev_q;
    wire do_update = upd_rise && upd_en_q;
    wire fin = fin_q && (state_q == ST_CALC);
    wire is_notify = (mode_q == AFPM_NOTIFY);

    // Software-written controls
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= AFPM_DISABLE;
            upd_cmd_q <= 1'b0;
            upd_prev_q <= 1'b0;
            ref_dev_q <= REF_DEV_RST;
            op_dev_q <= OP_DEV_RST;
            sp_q <= SETPOINT_RST;
        end else begin
            upd_prev_q <= upd_cmd_q;
            if (wr_now && sel_ctrl && avs_byteenable[0]) begin
                mode_q <= afpm_mode_type'(avs_writedata[CTRL_MODE_LSB +: 2]);
                upd_cmd_q <= avs_writedata[CTRL_UPD_BIT];
            end
            if (wr_now && sel_ref_dev) begin
                ref_dev_q <= merge16(ref_dev_q, avs_writedata, avs_byteenable);
            end
            if (wr_now && sel_op_dev) begin
                op_dev_q <= merge16(op_dev_q, avs_writedata, avs_byteenable);
            end
            if (wr_now && sel_sp) begin
                sp_q <= merge16(sp_q, avs_writedata, avs_byteenable);
            end
        end
    end

    // Model parameters: in notify and auto modes autotuning wins over a same-cycle software write
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            model <= '0;
        end else if (at_done && eval_mode) begin
            model <= at_model;
        end else if (wr_now && sel_model) begin
            case (midx)
                2'h0: model.pv_amp <= merge16(model.pv_amp, avs_writedata, avs_byteenable);
                2'h1: model.mv_amp <= merge16(model.mv_amp, avs_writedata, avs_byteenable);
                2'h2: model.on_time <= merge16(model.on_time, avs_writedata, avs_byteenable);
                default: model.off_time <= merge16(model.off_time, avs_writedata,
                                                   avs_byteenable);
            endcase
        end
    end

    // Evaluation results, notification and PID sets
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 2'h0;
            ref_pb_q <= 16'h0000;
            avg_q <= 16'h0000;
            notify_q <= 1'b0;
            upd_en_q <= 1'b0;
            pend_q <= '0;
            act_pid <= '0;
        end else begin
            if (wr_now && sel_ref_pb) begin
                ref_pb_q <= merge16(ref_pb_q, avs_writedata, avs_byteenable);
            end
            if (eval_done && (state_q == ST_EVAL)) begin
                pend_q <= eval_pid;
            end
            if (do_update) begin
                act_pid <= pend_q;
                notify_q <= 1'b0;
                upd_en_q <= 1'b0;
            end
            if (do_update || at_done) begin
                avg_q <= 16'h0000;
            end
            if (fin) begin
                if (!settled) begin
                    cnt_q <= cnt_q + 2'h1;
                end
                if (cnt_q == REF_EVAL_NUM - 2'h1) begin
                    ref_pb_q <= pend_q.sp_pb;
                end
                if (mode_q == AFPM_AUTO) begin
                    act_pid <= pend_q;
                end else if (is_notify) begin
                    upd_en_q <= 1'b1;
                    if (settled && calc_fluct) begin
                        notify_q <= 1'b1;
                    end
                    // Mean of previous average and new result; first settled result seeds it
                    if (settled && !do_update && !at_done) begin
                        avg_q <= (avg_q == 16'h0000) ? calc_pct :
                                 16'((17'(avg_q) + 17'(calc_pct)) >> 1);
                    end
                end
            end
        end
    end

    // Assertions
    a_notify_settle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        notify_q |-> (cnt_q == SETTLE_EVAL_NUM)) else $error("notify before three evals");
    a_notify_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fin && is_notify && settled && calc_fluct) |=> notify_q)
        else $error("fluctuation not notified");
    a_small_fluct: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fin && is_notify && !calc_fluct && !notify_q) |=> (!notify_q && upd_en_q))
        else $error("small fluctuation handling wrong");
    a_update_apply: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (do_update && !fin) |=> (act_pid == $past(pend_q)) && (avg_q == 16'h0000))
        else $error("update not applied");
    a_avg_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
        at_done |=> (avg_q == 16'h0000)) else $error("average not cleared");
    a_ref_band: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fin && cnt_q == 2'h1) |=> (ref_pb_q == $past(pend_q.sp_pb)))
        else $error("reference band not stored");
    a_gate_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_IDLE && ctrl_start && !start_ok) |=> (state_q == ST_IDLE))
        else $error("evaluation started above limit");
    a_fixed_none: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_IDLE && mode_q == AFPM_FIXED) |=> (state_q == ST_IDLE))
        else $error("evaluation in fixed mode");
    a_auto_apply: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fin && mode_q == AFPM_AUTO) |=> (act_pid == $past(pend_q)))
        else $error("auto update missing");
    a_eval_ends: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_EVAL && eval_done) |-> ##[1:30] (state_q == ST_IDLE))
        else $error("evaluation does not end");
    c_notify: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(notify_q));
    c_update: cover property (@(posedge ref_clk) disable iff (!reset_n) do_update);
    c_auto: cover property (@(posedge ref_clk) disable iff (!reset_n)
        fin && mode_q == AFPM_AUTO);
endmodule : afpm_monitor
`default_nettype wire

// >>> design/afpm_pkg.sv
// Package for the adaptive PID fluctuation monitor: register map, field
// positions, reset values, evaluation counts and the carrier structs.
// Assumes a 32-bit Avalon-MM register bus and 16-bit tenths-scaled values.
`default_nettype none
package afpm_pkg;
    // Register byte offsets (word aligned)
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_STATUS = 6'h04;
    localparam logic [5:0] OFF_REF_DEV = 6'h08;
    localparam logic [5:0] OFF_OP_DEV = 6'h0c;
    localparam logic [5:0] OFF_REF_PB = 6'h10;
    localparam logic [5:0] OFF_AVG_DEV = 6'h14;
    localparam logic [5:0] OFF_SETPOINT = 6'h18;
    localparam logic [5:0] OFF_MODEL0 = 6'h20;
    localparam logic [5:0] OFF_MODEL3 = 6'h2c;
    localparam logic [5:0] OFF_ACT_PB = 6'h30;
    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_UPD_BIT = 2;
    // Status fields
    localparam int ST_EVAL_BIT = 0;
    localparam int ST_NOTIFY_BIT = 1;
    localparam int ST_UPDEN_BIT = 2;
    localparam int ST_CNT_LSB = 4;
    // Reset values
    localparam logic [15:0] OP_DEV_RST = 16'h01f4;
    localparam logic [15:0] REF_DEV_RST = 16'h0000;
    localparam logic [15:0] SETPOINT_RST = 16'h0000;
    // Evaluation counts and scale
    localparam logic [1:0] REF_EVAL_NUM = 2'h2;
    localparam logic [1:0] SETTLE_EVAL_NUM = 2'h3;
    localparam logic [9:0] PCT_SCALE = 10'h3e8;
    localparam int DIV_STEPS = 26;

    typedef enum logic [1:0] {
        AFPM_DISABLE = 2'h0,
        AFPM_FIXED = 2'h1,
        AFPM_NOTIFY = 2'h2,
        AFPM_AUTO = 2'h3
    } afpm_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EVAL = 2'b01,
        ST_CALC = 2'b11
    } afpm_state_type;

    typedef struct packed {
        logic [15:0] sp_pb;
        logic [15:0] sp_ti;
        logic [15:0] sp_td;
        logic [15:0] sp_coef;
        logic [15:0] dist_pb;
        logic [15:0] dist_ti;
        logic [15:0] dist_td;
    } afpm_pid_type;

    typedef struct packed {
        logic [15:0] pv_amp;
        logic [15:0] mv_amp;
        logic [15:0] on_time;
        logic [15:0] off_time;
    } afpm_model_type;
endpackage : afpm_pkg
`default_nettype wire

// >>> design/afpm_fluct_calc.sv
// Fluctuation comparison and deviation percentage for one evaluation.
// Assumes start is a one-cycle pulse and inputs stand while busy.
`default_nettype none
module afpm_fluct_calc
    import afpm_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic start, // Begin one comparison
    input wire logic [15:0] ref_pb, // Reference band, tenths
    input wire logic [15:0] new_pb, // New band, tenths
    input wire logic [15:0] ref_dev, // Reference deviation, tenths of percent
    output logic done, // One-cycle result pulse
    output logic fluct, // Fluctuation found
    output logic [15:0] pct // Deviation, tenths of percent
);
    logic [15:0] diff;
    logic [25:0] scaled;
    logic [31:0] lhs;
    logic [16:0] rem_sh;
    logic [25:0] num_q;
    logic [16:0] rem_q;
    logic [4:0] step_q;
    logic busy_q;

    assign diff = (ref_pb >= new_pb) ? ref_pb - new_pb : new_pb - ref_pb;
    assign scaled = diff * PCT_SCALE;
    assign lhs = ref_dev * ref_pb;
    assign rem_sh = {rem_q[15:0], num_q[25]};

    // Multiply across instead of dividing so that equality counts exactly
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fluct <= 1'b0;
        end else if (start) begin
            fluct <= (ref_pb != 16'h0000) && (lhs <= {6'h00, scaled});
        end
    end

    // Restoring divider, one quotient bit per clock
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            step_q <= 5'h00;
            num_q <= 26'h0;
            rem_q <= 17'h0;
            done <= 1'b0;
            pct <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy_q <= (ref_pb != 16'h0000);
                done <= (ref_pb == 16'h0000);
                pct <= 16'h0000;
                step_q <= 5'h00;
                // A zero reference band yields no division, so report 0.0 percent
                num_q <= (ref_pb != 16'h0000) ? scaled : 26'h0;
                rem_q <= 17'h0;
            end else if (busy_q) begin
                if (rem_sh >= {1'b0, ref_pb}) begin
                    rem_q <= rem_sh - {1'b0, ref_pb};
                    num_q <= {num_q[24:0], 1'b1};
                end else begin
                    rem_q <= rem_sh;
                    num_q <= {num_q[24:0], 1'b0};
                end
                step_q <= step_q + 5'h01;
                if (step_q == 5'(DIV_STEPS - 1)) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end
            end else if (done) begin
                pct <= (num_q[25:16] != 10'h000) ? 16'hffff : num_q[15:0];
            end
        end
    end
endmodule : afpm_fluct_calc
`default_nettype wire

// >>> tb/afpm_eng_model.sv
// Stand-in for the PID arithmetic and autotuner that feed the monitor.
// Assumes the bench calls its tasks from its own process on ref_clk.
`default_nettype none
module afpm_eng_model
    import afpm_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    output logic at_done, // Pulse: tuning finished
    output afpm_pkg::afpm_model_type at_model, // Tuned model
    output logic eval_done, // Pulse: evaluation results ready
    output afpm_pkg::afpm_pid_type eval_pid // Computed PID sets
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        at_done = 1'b0;
        eval_done = 1'b0;
        at_model = '0;
        eval_pid = '0;
    end
    // Results hold only in the pulse cycle; inverted afterwards so a late
    // sample in the design shows up as a wrong value, not a stale match
    task automatic tune(input afpm_model_type m);
        @(posedge ref_clk);
        at_done <= 1'b1;
        at_model <= m;
        @(posedge ref_clk);
        at_done <= 1'b0;
        at_model <= ~m;
    endtask : tune
    task automatic evaluate(input afpm_pid_type p, input int lat);
        repeat (lat) @(posedge ref_clk);
        eval_done <= 1'b1;
        eval_pid <= p;
        @(posedge ref_clk);
        eval_done <= 1'b0;
        eval_pid <= ~p;
    endtask : evaluate
endmodule : afpm_eng_model
`default_nettype wire

// >>> tb/afpm_monitor_tb.sv
// Self-checking bench for the fluctuation monitor: register access over
// Avalon-MM, evaluation runs fed by the engine model, mode handling.
`default_nettype none
module afpm_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import afpm_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ctrl_start = 1'b0;
    logic [15:0] pv = '0;
    logic at_done;
    logic eval_done;
    afpm_model_type at_model;
    afpm_pid_type eval_pid;
    afpm_pid_type act_pid;
    afpm_model_type model;
    logic eval_state;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    afpm_model_type tm = {16'h0032, 16'h0064, 16'h001e, 16'h0028};

    always #25 ref_clk = ~ref_clk;

    afpm_monitor i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ctrl_start(ctrl_start), .pv(pv),
        .at_done(at_done), .at_model(at_model), .eval_done(eval_done),
        .eval_pid(eval_pid), .act_pid(act_pid), .model(model), .eval_state(eval_state));
    afpm_eng_model i_eng (.ref_clk(ref_clk), .reset_n(reset_n), .at_done(at_done),
        .at_model(at_model), .eval_done(eval_done), .eval_pid(eval_pid));

    task automatic results;
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One request, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'h3;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rchk(input string name, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        chk(name, exp, rd);
    endtask : rchk

    function automatic afpm_pid_type mk_pid(input logic [15:0] pb);
        return {pb, 16'h00c8, 16'h0028, 16'h0032, pb + 16'h0010, 16'h00f0, 16'h001e};
    endfunction : mk_pid

    // Start a control run; evaluate only when the gate lets it through
    task automatic run_eval(input logic [15:0] pv_v, input logic [15:0] pb, input logic go);
        int n;
        @(posedge ref_clk);
        ctrl_start <= 1'b1;
        pv <= pv_v;
        @(posedge ref_clk);
        ctrl_start <= 1'b0;
        @(negedge ref_clk);
        chk("eval_state", go, eval_state);
        if (go) begin
            i_eng.evaluate(mk_pid(pb), 3);
            n = 0;
            while (eval_state !== 1'b0 && n < 60) begin
                @(posedge ref_clk);
                n++;
            end
            chk("eval_end", 1'b0, eval_state);
        end
    endtask : run_eval

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rchk("op_dev_rst", OFF_OP_DEV, 32'h1f4);
        rchk("ref_dev_rst", OFF_REF_DEV, 32'h0);
        rchk("status_rst", OFF_STATUS, 32'h0);
        rchk("unmapped", 6'h3c, 32'h0);
        bus(1'b1, OFF_SETPOINT, 32'haf0);
        bus(1'b1, OFF_OP_DEV, 32'h1f4);
        bus(1'b1, OFF_REF_DEV, 32'h96);
        bus(1'b1, OFF_CTRL, 32'h2);
        i_eng.tune(tm);
        @(negedge ref_clk);
        chk("model", tm, model);
        rchk("avg_after_tune", OFF_AVG_DEV, 32'h0);
        bus(1'b1, OFF_MODEL3, 32'h55);
        rchk("model3", OFF_MODEL3, 32'h55);
        run_eval(16'h0579, 16'h03e8, 1'b0);
        run_eval(16'h0578, 16'h03e8, 1'b1);
        run_eval(16'h0100, 16'h03e8, 1'b1);
        rchk("ref_pb", OFF_REF_PB, 32'h3e8);
        run_eval(16'h0100, 16'h03e8, 1'b1);
        rchk("status_3", OFF_STATUS, 32'h34);
        run_eval(16'h0100, 16'h047d, 1'b1);
        rchk("status_1149", OFF_STATUS, 32'h34);
        run_eval(16'h0100, 16'h047e, 1'b1);
        rchk("status_1150", OFF_STATUS, 32'h36);
        rchk("avg_kept", OFF_AVG_DEV, 32'h95);
        chk("notify_no_apply", 16'h0, act_pid.sp_pb);
        bus(1'b1, OFF_CTRL, 32'h2);
        bus(1'b1, OFF_CTRL, 32'h6);
        rchk("act_pb", OFF_ACT_PB, 32'h47e);
        rchk("avg_after_upd", OFF_AVG_DEV, 32'h0);
        rchk("status_upd", OFF_STATUS, 32'h30);
        bus(1'b1, OFF_CTRL, 32'h3);
        run_eval(16'h0100, 16'h0384, 1'b1);
        chk("auto_pid", mk_pid(16'h0384), act_pid);
        bus(1'b1, OFF_CTRL, 32'h1);
        run_eval(16'h0100, 16'h0200, 1'b0);
        chk("fixed_pid", mk_pid(16'h0384), act_pid);
        i_eng.tune(~tm);
        @(negedge ref_clk);
        chk("model_fixed", {16'h0032, 16'h0064, 16'h001e, 16'h0055}, model);
        bus(1'b1, OFF_CTRL, 32'h2);
        run_eval(16'h0100, 16'h0384, 1'b1);
        rchk("avg_seed", OFF_AVG_DEV, 32'h64);
        i_eng.tune(tm);
        rchk("avg_tune_clr", OFF_AVG_DEV, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h0);
        run_eval(16'h0100, 16'h0200, 1'b0);
        results();
    end
endmodule : afpm_monitor_tb
`default_nettype wire
